// file: hw/lmr_core_regs.vh
// Register offsets, field positions, reset values and opcode patterns for the lmr core
`ifndef LMR_CORE_REGS_VH
`define LMR_CORE_REGS_VH

// Byte offsets of the bus registers
`define LMR_OFS_INSTR      8'h00
`define LMR_OFS_ACC        8'h04
`define LMR_OFS_STATUS     8'h08
`define LMR_OFS_PC         8'h0C
`define LMR_OFS_STACK_TOP  8'h10
`define LMR_OFS_FILE_ADDR  8'h14
`define LMR_OFS_FILE_DATA  8'h18

// Status register fields
`define LMR_ST_CARRY       0
`define LMR_ST_PD_N        3
`define LMR_ST_TO_N        4
`define LMR_ST_GIE         7
`define LMR_ST_BUSY        8
`define LMR_ST_SLEEP       9
`define LMR_ST_ILLEGAL     10
`define LMR_ST_DROPPED     11

// Reset values
`define LMR_RST_ACC        8'h00
`define LMR_RST_PC         13'h0000
`define LMR_RST_TO_N       1'b1
`define LMR_RST_PD_N       1'b1
`define LMR_RST_WDT        8'h00

// Opcode patterns: an instruction matches when (op & MASK) == MATCH
`define LMR_MSK_LIT        14'h3C00
`define LMR_OP_MOVE_LIT    14'h3000
`define LMR_OP_RET_LIT     14'h3400
`define LMR_MSK_STORE      14'h3F80
`define LMR_OP_STORE       14'h0080
`define LMR_MSK_ROT        14'h3F00
`define LMR_OP_ROT         14'h0D00
`define LMR_MSK_NOP        14'h3F9F
`define LMR_OP_NOP         14'h0000
`define LMR_OP_SLEEP       14'h0063
`define LMR_OP_RETURN      14'h0008
`define LMR_OP_RET_IRQ     14'h0009
`define LMR_DEST_BIT       7

// Return stack depth and pointer width
`define LMR_STACK_DEPTH    8
`define LMR_STACK_PTR_W    3

`endif

// file: hw/lmr_file_regs.v
// Flip-flop file register bank with one write port and two read ports
`timescale 1ns/1ps
module lmr_file_regs (
	input  wire       sys_clk_i,
	input  wire       reset_n_i,
	input  wire       we_i,
	input  wire [6:0] waddr_i,
	input  wire [7:0] wdata_i,
	input  wire [6:0] raddr_a_i,
	output wire [7:0] rdata_a_o,
	input  wire [6:0] raddr_b_i,
	output wire [7:0] rdata_b_o
);
	reg [7:0] mem [0:127];
	integer   i;

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (i = 0; i < 128; i = i + 1) begin
				mem[i] <= 8'h00;
			end
		end else if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_a_o = mem[raddr_a_i];
	assign rdata_b_o = mem[raddr_b_i];
endmodule

// file: hw/lmr_ret_stack.v
// Circular return-address stack built from flip-flops
`timescale 1ns/1ps
`include "lmr_core_regs.vh"
module lmr_ret_stack (
	input  wire        sys_clk_i,
	input  wire        reset_n_i,
	input  wire        push_i,
	input  wire [12:0] push_data_i,
	input  wire        pop_i,
	output wire [12:0] top_o
);
	reg [12:0]                  entry [0:`LMR_STACK_DEPTH-1];
	reg [`LMR_STACK_PTR_W-1:0]  ptr;
	integer                     i;

	// Overflow wraps silently, as a real call stack of fixed depth does
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ptr <= {`LMR_STACK_PTR_W{1'b0}};
			for (i = 0; i < `LMR_STACK_DEPTH; i = i + 1) begin
				entry[i] <= 13'h0000;
			end
		end else if (push_i) begin
			entry[ptr + 1'b1] <= push_data_i;
			ptr               <= ptr + 1'b1;
		end else if (pop_i) begin
			ptr <= ptr - 1'b1;
		end
	end

	assign top_o = entry[ptr];
endmodule

// file: hw/lmr_core.v
// Executes the literal, move, return, rotate and sleep instructions behind an AHB-Lite slave
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "lmr_core_regs.vh"
// Notes on behaviour
// - Loading a literal copies the 8-bit operand into the accumulator and touches no flag.
// - Storing the accumulator writes it to the file register at the 7-bit address, no flags.
// - Return-with-literal loads the operand into the accumulator and the PC from stack top.
// - Return-with-literal takes two instruction cycles since the PC is replaced.
// - Rotate-left shifts the file register left, old carry into bit 0, bit 7 into carry.
// - For rotate-left, destination bit 0 sends the result to the accumulator, 1 to the file.
// - Sleep clears the watchdog and its prescaler, sets timeout flag, clears power-down flag.
// - After sleep the core enters low-power sleep, stops the oscillator and halts execution.
// - Subroutine return pops the stack and loads the popped top entry into the PC.
// - Subroutine return takes two instruction cycles.
module lmr_core (
	input  wire        sys_clk_i,
	input  wire        reset_n_i,
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg         hreadyout_o,
	output reg         hresp_o,
	output reg  [31:0] hrdata_o,
	input  wire        wake_i,
	output reg         wdt_clear_o,
	output reg         sleep_o,
	output reg         osc_stop_o,
	output reg         global_irq_enable_o
);
	localparam ST_IDLE   = 2'b00;
	localparam ST_SECOND = 2'b01;
	localparam ST_SLEEP  = 2'b10;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [7:0]  acc;
	reg  [12:0] pc;
	reg         carry;
	reg         timeout_flag_n;
	reg         power_down_flag_n;
	reg         illegal;
	reg         dropped;
	reg  [6:0]  file_addr;
	reg         wr_pend;
	reg  [7:0]  wr_addr;
	reg         rd_pend;
	reg  [7:0]  rd_addr;
	reg         wake_meta;
	reg         wake_sync;
	reg  [31:0] rd_mux;
	reg  [31:0] status_word;
	reg         file_we;
	reg  [6:0]  file_waddr;
	reg  [7:0]  file_wdata;

	wire        accept;
	wire        wr_instr;
	wire        exec;
	wire [13:0] op;
	wire        is_move_lit;
	wire        is_ret_lit;
	wire        is_store;
	wire        is_rot;
	wire        is_nop;
	wire        is_sleep;
	wire        is_return;
	wire        is_ret_irq;
	wire        is_pop;
	wire        rot_to_file;
	wire [7:0]  op_file_data;
	wire [7:0]  sw_file_data;
	wire [7:0]  rot_result;
	wire [12:0] stack_top_entry;
	wire        stack_push;

	assign accept   = hsel_i & htrans_i[1] & hready_i;
	assign wr_instr = wr_pend & (wr_addr == `LMR_OFS_INSTR);
	// Instructions are taken only while idle; others are dropped and flagged
	assign exec     = wr_instr & (state == ST_IDLE);
	assign op       = hwdata_i[13:0];

	assign is_move_lit = (op & `LMR_MSK_LIT) == `LMR_OP_MOVE_LIT;
	assign is_ret_lit  = (op & `LMR_MSK_LIT) == `LMR_OP_RET_LIT;
	assign is_store    = (op & `LMR_MSK_STORE) == `LMR_OP_STORE;
	assign is_rot      = (op & `LMR_MSK_ROT) == `LMR_OP_ROT;
	assign is_nop      = (op & `LMR_MSK_NOP) == `LMR_OP_NOP;
	assign is_sleep    = op == `LMR_OP_SLEEP;
	assign is_return   = op == `LMR_OP_RETURN;
	assign is_ret_irq  = op == `LMR_OP_RET_IRQ;
	assign is_pop      = is_ret_lit | is_return | is_ret_irq;
	assign rot_to_file = op[`LMR_DEST_BIT];

	assign rot_result = {op_file_data[6:0], carry};

	// Execution has priority on the single write port; a bus write to the
	// data register cannot coincide because both come from one bus commit
	always @* begin
		file_we    = 1'b0;
		file_waddr = file_addr;
		file_wdata = hwdata_i[7:0];
		if (exec) begin
			file_waddr = op[6:0];
			if (is_store) begin
				file_we    = 1'b1;
				file_wdata = acc;
			end else if (is_rot & rot_to_file) begin
				file_we    = 1'b1;
				file_wdata = rot_result;
			end
		end else if (wr_pend & (wr_addr == `LMR_OFS_FILE_DATA)) begin
			file_we = 1'b1;
		end
	end

	assign stack_push = wr_pend & (wr_addr == `LMR_OFS_STACK_TOP);

	// Fields placed by the shared bit positions so reads and writes agree
	always @* begin
		status_word                  = 32'h00000000;
		status_word[`LMR_ST_CARRY]   = carry;
		status_word[`LMR_ST_PD_N]    = power_down_flag_n;
		status_word[`LMR_ST_TO_N]    = timeout_flag_n;
		status_word[`LMR_ST_GIE]     = global_irq_enable_o;
		status_word[`LMR_ST_BUSY]    = (state == ST_SECOND);
		status_word[`LMR_ST_SLEEP]   = sleep_o;
		status_word[`LMR_ST_ILLEGAL] = illegal;
		status_word[`LMR_ST_DROPPED] = dropped;
	end

	lmr_file_regs u_file_regs (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.we_i      (file_we),
		.waddr_i   (file_waddr),
		.wdata_i   (file_wdata),
		.raddr_a_i (op[6:0]),
		.rdata_a_o (op_file_data),
		.raddr_b_i (file_addr),
		.rdata_b_o (sw_file_data)
	);

	// Filled by software through the stack register; calls sit outside this block
	lmr_ret_stack u_ret_stack (
		.sys_clk_i   (sys_clk_i),
		.reset_n_i   (reset_n_i),
		.push_i      (stack_push),
		.push_data_i (hwdata_i[12:0]),
		.pop_i       (exec & is_pop),
		.top_o       (stack_top_entry)
	);

	always @* begin
		case (rd_addr)
			`LMR_OFS_ACC:       rd_mux = {24'h000000, acc};
			`LMR_OFS_STATUS:    rd_mux = status_word;
			`LMR_OFS_PC:        rd_mux = {19'h00000, pc};
			`LMR_OFS_STACK_TOP: rd_mux = {19'h00000, stack_top_entry};
			`LMR_OFS_FILE_ADDR: rd_mux = {25'h0000000, file_addr};
			`LMR_OFS_FILE_DATA: rd_mux = {24'h000000, sw_file_data};
			default:            rd_mux = 32'h00000000;
		endcase
	end

	// Reads take one wait state so that a write just ahead is already visible
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			hrdata_o    <= 32'h00000000;
			wr_pend     <= 1'b0;
			wr_addr     <= 8'h00;
			rd_pend     <= 1'b0;
			rd_addr     <= 8'h00;
		end else begin
			hresp_o <= 1'b0;
			wr_pend <= accept & hwrite_i;
			rd_pend <= accept & ~hwrite_i;
			if (accept) begin
				wr_addr <= {haddr_i[7:2], 2'b00};
				rd_addr <= {haddr_i[7:2], 2'b00};
			end
			if (accept & ~hwrite_i) begin
				hreadyout_o <= 1'b0;
			end else if (rd_pend) begin
				hrdata_o    <= rd_mux;
				hreadyout_o <= 1'b1;
			end
		end
	end

	// Wake pin comes from outside this clock, so only the second flop is read
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end else begin
			wake_meta <= wake_i;
			wake_sync <= wake_meta;
		end
	end

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (exec & is_pop) begin
					next_state = ST_SECOND;
				end else if (exec & is_sleep) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SECOND: next_state = ST_IDLE;
			ST_SLEEP: begin
				if (wake_sync) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state               <= ST_IDLE;
			acc                 <= `LMR_RST_ACC;
			pc                  <= `LMR_RST_PC;
			carry               <= 1'b0;
			timeout_flag_n      <= `LMR_RST_TO_N;
			power_down_flag_n   <= `LMR_RST_PD_N;
			global_irq_enable_o <= 1'b0;
			illegal             <= 1'b0;
			dropped             <= 1'b0;
			file_addr           <= 7'h00;
			wdt_clear_o         <= 1'b0;
			sleep_o             <= 1'b0;
			osc_stop_o          <= 1'b0;
		end else begin
			state       <= next_state;
			wdt_clear_o <= 1'b0;
			sleep_o     <= (next_state == ST_SLEEP);
			osc_stop_o  <= (next_state == ST_SLEEP);
			// Set wins over a software clear of the sticky flags
			if (wr_pend & (wr_addr == `LMR_OFS_STATUS)) begin
				carry               <= hwdata_i[`LMR_ST_CARRY];
				global_irq_enable_o <= hwdata_i[`LMR_ST_GIE];
				if (hwdata_i[`LMR_ST_ILLEGAL]) begin
					illegal <= 1'b0;
				end
				if (hwdata_i[`LMR_ST_DROPPED]) begin
					dropped <= 1'b0;
				end
			end
			if (wr_pend & (wr_addr == `LMR_OFS_ACC)) begin
				acc <= hwdata_i[7:0];
			end
			if (wr_pend & (wr_addr == `LMR_OFS_PC)) begin
				pc <= hwdata_i[12:0];
			end
			if (wr_pend & (wr_addr == `LMR_OFS_FILE_ADDR)) begin
				file_addr <= hwdata_i[6:0];
			end
			if (wr_instr & (state != ST_IDLE)) begin
				dropped <= 1'b1;
			end
			if (exec) begin
				if (is_move_lit) begin
					acc <= op[7:0];
					pc  <= pc + 13'h0001;
				end else if (is_ret_lit) begin
					acc <= op[7:0];
					pc  <= stack_top_entry;
				end else if (is_store) begin
					pc <= pc + 13'h0001;
				end else if (is_rot) begin
					carry <= op_file_data[7];
					if (!rot_to_file) begin
						acc <= rot_result;
					end
					pc <= pc + 13'h0001;
				end else if (is_sleep) begin
					// The watchdog sits outside; this pulse clears it and its prescaler
					wdt_clear_o       <= 1'b1;
					timeout_flag_n    <= 1'b1;
					power_down_flag_n <= 1'b0;
					pc                <= pc + 13'h0001;
				end else if (is_return) begin
					pc <= stack_top_entry;
				end else if (is_ret_irq) begin
					pc                  <= stack_top_entry;
					global_irq_enable_o <= 1'b1;
				end else if (is_nop) begin
					pc <= pc + 13'h0001;
				end else begin
					// Unknown codes act as no-operation but are flagged
					illegal <= 1'b1;
					pc      <= pc + 13'h0001;
				end
			end
		end
	end
endmodule

// file: tb/lmr_core_assertions.sv
// Port-level checker for the lmr core
`timescale 1ns/1ps
module lmr_core_assertions (
	input wire       sys_clk_i,
	input wire       reset_n_i,
	input wire       hsel_i,
	input wire [1:0] htrans_i,
	input wire       hwrite_i,
	input wire       hready_i,
	input wire       hreadyout_o,
	input wire       hresp_o,
	input wire       wake_i,
	input wire       wdt_clear_o,
	input wire       sleep_o,
	input wire       osc_stop_o,
	input wire       global_irq_enable_o
);
	reg  wr_dp;
	wire take = hsel_i & htrans_i[1] & hready_i;
	// Tracks a write data phase so effects can be tied to its commit edge
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			wr_dp <= 1'b0;
		else if (hready_i)
			wr_dp <= take & hwrite_i;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	a_resp_okay: assert property (hresp_o == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write was stalled");
	a_clear_pulse: assert property ($rose(wdt_clear_o) |=> !wdt_clear_o)
		else $error("watchdog clear not one cycle");
	a_sleep_cause: assert property ($rose(sleep_o) |-> wdt_clear_o && $past(wr_dp && hready_i))
		else $error("sleep entry without commit and clear");
	a_osc_stop: assert property (osc_stop_o == sleep_o)
		else $error("oscillator stop differs from sleep");
	a_sleep_hold: assert property ($fell(sleep_o) |-> $past(wake_i, 2))
		else $error("sleep left without wake");
	a_wake_exit: assert property (sleep_o && wake_i |-> ##[1:4] !sleep_o)
		else $error("wake did not end sleep");
	a_irq_set: assert property ($rose(global_irq_enable_o) |-> $past(wr_dp && hready_i))
		else $error("interrupt enable rose without commit");
	c_sleep: cover property ($rose(sleep_o));
	c_irq: cover property ($rose(global_irq_enable_o));
	c_read: cover property (take && !hwrite_i);
endmodule

// file: tb/tb_literal_move_return_sleep_ops.sv
// Self-checking bench for the lmr core
`timescale 1ns/1ps
`include "lmr_core_regs.vh"
module tb_literal_move_return_sleep_ops;
	reg         sys_clk_i = 1'b0;
	reg         reset_n_i = 1'b0;
	reg         hsel_i    = 1'b0;
	reg  [31:0] haddr_i   = 32'h0;
	reg  [1:0]  htrans_i  = 2'h0;
	reg         hwrite_i  = 1'b0;
	reg  [2:0]  hsize_i   = 3'h2;
	reg  [31:0] hwdata_i  = 32'h0;
	reg         wake_i    = 1'b0;
	wire        hready;
	wire        hresp;
	wire [31:0] hrdata;
	wire        wd_clr;
	wire        sleep;
	wire        osc;
	wire        irq_en;
	integer     mismatches = 0;
	integer     tests_run  = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	lmr_core uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
		.hwdata_i(hwdata_i), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
		.hrdata_o(hrdata), .wake_i(wake_i), .wdt_clear_o(wd_clr), .sleep_o(sleep),
		.osc_stop_o(osc), .global_irq_enable_o(irq_en));
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] exp, input [31:0] got);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task bus_wait;
		begin
			@(posedge sys_clk_i);
			while (hready !== 1'b1) @(posedge sys_clk_i);
		end
	endtask
	task xfer(input is_wr, input [7:0] a, input [31:0] wd, output [31:0] rd);
		begin
			hsel_i   <= 1'b1;
			haddr_i  <= {24'h0, a};
			hwrite_i <= is_wr;
			htrans_i <= 2'h2;
			bus_wait;
			htrans_i <= 2'h0;
			hwdata_i <= wd;
			bus_wait;
			rd = hrdata;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		reg [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task rd_chk(input string nm, input [7:0] a, input [31:0] exp);
		reg [31:0] x;
		begin
			xfer(1'b0, a, 32'h0, x);
			check(nm, exp, x);
			check("hresp", 32'h0, {31'h0, hresp});
		end
	endtask
	// Two instructions as back-to-back single transfers, not pipelined, so the second is taken after the busy cycle
	task wr_pair(input [31:0] op1, input [31:0] op2);
		begin
			wr(`LMR_OFS_INSTR, op1);
			wr(`LMR_OFS_INSTR, op2);
		end
	endtask
	task t_reset;
		begin
			rd_chk("acc", `LMR_OFS_ACC, 32'h0);
			rd_chk("status", `LMR_OFS_STATUS, 32'h18);
			rd_chk("pc", `LMR_OFS_PC, 32'h0);
			rd_chk("unmapped", 8'h1C, 32'h0);
		end
	endtask
	task t_rotate;
		begin
			wr(`LMR_OFS_FILE_ADDR, 32'h10);
			wr(`LMR_OFS_FILE_DATA, 32'h81);
			wr(`LMR_OFS_INSTR, `LMR_OP_ROT | 14'h0090);
			rd_chk("file", `LMR_OFS_FILE_DATA, 32'h02);
			rd_chk("status", `LMR_OFS_STATUS, 32'h19);
			wr(`LMR_OFS_INSTR, `LMR_OP_ROT | 14'h0010);
			rd_chk("acc", `LMR_OFS_ACC, 32'h05);
			rd_chk("file", `LMR_OFS_FILE_DATA, 32'h02);
			rd_chk("status", `LMR_OFS_STATUS, 32'h18);
		end
	endtask
	task t_literal;
		begin
			wr(`LMR_OFS_STATUS, 32'h1);
			wr(`LMR_OFS_INSTR, `LMR_OP_MOVE_LIT | 14'h00FF);
			rd_chk("acc", `LMR_OFS_ACC, 32'hFF);
			rd_chk("status", `LMR_OFS_STATUS, 32'h19);
			wr(`LMR_OFS_INSTR, `LMR_OP_STORE | 14'h007F);
			wr(`LMR_OFS_FILE_ADDR, 32'h7F);
			rd_chk("file", `LMR_OFS_FILE_DATA, 32'hFF);
			rd_chk("status", `LMR_OFS_STATUS, 32'h19);
		end
	endtask
	task t_nop;
		begin
			rd_chk("pc", `LMR_OFS_PC, 32'h4);
			wr(`LMR_OFS_INSTR, `LMR_OP_NOP);
			rd_chk("pc", `LMR_OFS_PC, 32'h5);
			rd_chk("acc", `LMR_OFS_ACC, 32'hFF);
			rd_chk("status", `LMR_OFS_STATUS, 32'h19);
			wr(`LMR_OFS_INSTR, 32'h3FFF);
			rd_chk("status", `LMR_OFS_STATUS, 32'h419);
			rd_chk("pc", `LMR_OFS_PC, 32'h6);
			wr(`LMR_OFS_STATUS, 32'h401);
			rd_chk("status", `LMR_OFS_STATUS, 32'h19);
		end
	endtask
	task t_return;
		begin
			wr(`LMR_OFS_STATUS, 32'h0);
			wr(`LMR_OFS_STACK_TOP, 32'h111);
			wr(`LMR_OFS_STACK_TOP, 32'h123);
			wr_pair(`LMR_OP_RETURN, `LMR_OP_MOVE_LIT | 14'h0022);
			rd_chk("pc", `LMR_OFS_PC, 32'h124);
			rd_chk("acc", `LMR_OFS_ACC, 32'h22);
			rd_chk("status", `LMR_OFS_STATUS, 32'h18);
			wr(`LMR_OFS_STATUS, 32'h800);
			wr(`LMR_OFS_INSTR, `LMR_OP_RET_IRQ);
			rd_chk("pc", `LMR_OFS_PC, 32'h111);
			check("irq_en", 32'h1, {31'h0, irq_en});
			rd_chk("status", `LMR_OFS_STATUS, 32'h98);
			wr(`LMR_OFS_STACK_TOP, 32'hABC);
			wr_pair(`LMR_OP_RET_LIT | 14'h00A5, `LMR_OP_NOP);
			rd_chk("acc", `LMR_OFS_ACC, 32'hA5);
			rd_chk("pc", `LMR_OFS_PC, 32'hABD);
			rd_chk("status", `LMR_OFS_STATUS, 32'h98);
		end
	endtask
	task t_sleep;
		begin
			wr(`LMR_OFS_STATUS, 32'h880);
			wr(`LMR_OFS_INSTR, `LMR_OP_SLEEP);
			@(negedge sys_clk_i);
			check("wd_clr", 32'h1, {31'h0, wd_clr});
			check("sleep", 32'h1, {31'h0, sleep});
			check("osc", 32'h1, {31'h0, osc});
			@(posedge sys_clk_i);
			rd_chk("status", `LMR_OFS_STATUS, 32'h290);
			check("wd_clr", 32'h0, {31'h0, wd_clr});
			wr(`LMR_OFS_INSTR, `LMR_OP_MOVE_LIT | 14'h0033);
			rd_chk("acc", `LMR_OFS_ACC, 32'hA5);
			rd_chk("status", `LMR_OFS_STATUS, 32'hA90);
			wake_i <= 1'b1;
			repeat (5) @(posedge sys_clk_i);
			wake_i <= 1'b0;
			check("sleep", 32'h0, {31'h0, sleep});
			check("osc", 32'h0, {31'h0, osc});
			wr(`LMR_OFS_INSTR, `LMR_OP_MOVE_LIT | 14'h0033);
			rd_chk("acc", `LMR_OFS_ACC, 32'h33);
		end
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_rotate;
		t_literal;
		t_nop;
		t_return;
		t_sleep;
		end_sim;
	end
	// Whole sequence needs under two hundred cycles
	initial begin
		#100000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule
bind lmr_core lmr_core_assertions u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
	.hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .wake_i(wake_i),
	.wdt_clear_o(wdt_clear_o), .sleep_o(sleep_o), .osc_stop_o(osc_stop_o),
	.global_irq_enable_o(global_irq_enable_o));
